// ---- logic/dip_config_pkg.sv ----
package dip_config_pkg;

  // clock and time base
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int SETTLE_US = 20; // bounce window; short so power-on stays brief
  localparam int SETTLE_TICKS = SETTLE_US * 1000 / TICK_NS;

  // switch positions inside one block (switch n sits at bit n-1)
  localparam int SW_COUNT = 8;
  localparam int SW_FOUR_SENSOR = 0;
  localparam int SW_SEQUENCE = 1;
  localparam int SW_EXTENSION = 2;
  localparam int SW_RESTART_MANUAL = 3;
  localparam int SW_MUTE_FROM_SENSOR = 4;
  localparam int SW_RESET_FROM_CONTROL = 5;
  localparam int SW_TIMEOUT_FIRST = 6;
  localparam int SW_TIMEOUT_SECOND = 7;

  // muting timeouts, as printed, and in seconds
  localparam int TIMEOUT_SHORT_S = 20;
  localparam int TIMEOUT_MID_MIN = 2;
  localparam int TIMEOUT_LONG_MIN = 10;
  localparam int TIMEOUT_MAX_H = 100;
  localparam logic [18:0] TIMEOUT_SHORT_SEC = 19'(TIMEOUT_SHORT_S);
  localparam logic [18:0] TIMEOUT_MID_SEC = 19'(TIMEOUT_MID_MIN * 60);
  localparam logic [18:0] TIMEOUT_LONG_SEC = 19'(TIMEOUT_LONG_MIN * 60);
  localparam logic [18:0] TIMEOUT_MAX_SEC = 19'(TIMEOUT_MAX_H * 3600);

  // operating mode numbering
  localparam logic [5:0] MODE_TIMING_BASE = 6'h01;
  localparam logic [5:0] MODE_SEQ2_BASE = 6'h11;
  localparam logic [5:0] MODE_SEQ4_BASE = 6'h31;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_LIVE = 8'h10;

  // status / mask bits
  localparam int ST_MISMATCH = 0;
  localparam int ST_CHANGED = 1;
  localparam int ST_MODE_ERROR = 2;
  localparam int ST_READY = 3;
  localparam int ST_WIDTH = 4;

  // config register fields
  localparam int CFG_VALID_BIT = 8;
  localparam int CFG_MODE_LSB = 16;

  // reset values
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 4'h0;
  localparam logic CONTROL_ENABLE_RESET = 1'b0;

  typedef enum logic [1:0] {
    LOAD_SETTLE = 2'b00,
    LOAD_RUN = 2'b01,
    LOAD_FAULT = 2'b10
  } load_state_type;

endpackage

// ---- logic/mode_display.sv ----
`timescale 1ns/1ps
// two-digit seven-segment driver for the operating mode number
module mode_display (
  input wire logic clk,
  input wire logic reset,
  input wire logic show,
  input wire logic fault,
  input wire logic [5:0] mode,
  output logic [6:0] tens_seg,
  output logic [6:0] ones_seg
);
  import dip_config_pkg::*;

  // segments g..a, active high
  function automatic logic [6:0] seg_of(input logic [3:0] digit);
    case (digit)
      4'h0: seg_of = 7'h3f;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5b;
      4'h3: seg_of = 7'h4f;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6d;
      4'h6: seg_of = 7'h7d;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7f;
      4'h9: seg_of = 7'h6f;
      4'he: seg_of = 7'h79;
      default: seg_of = 7'h00;
    endcase
  endfunction

  logic [3:0] tens;
  logic [3:0] ones;

  // binary to two decimal digits, mode never exceeds 63
  always_comb begin
    tens = 4'(mode / 6'd10);
    ones = 4'(mode % 6'd10);
  end

  // blank until start-up done, fault shows "E" blank
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tens_seg <= 7'h00;
      ones_seg <= 7'h00;
    end else if (fault) begin
      tens_seg <= seg_of(4'he);
      ones_seg <= 7'h00;
    end else if (show) begin
      tens_seg <= seg_of(tens);
      ones_seg <= seg_of(ones);
    end else begin
      tens_seg <= 7'h00;
      ones_seg <= 7'h00;
    end
  end

endmodule

// ---- logic/dip_config_validator.sv ----
// Contract
// - Configuration comes from two eight-switch blocks, the second a redundant copy of the first.
// - Any switch differing between the two blocks flags a configuration error and drops both safety outputs.
// - Any switch change during normal operation flags an error and drops both safety outputs.
// - A setting that matches no permitted operating mode raises a mode error and drops both safety outputs.
// - After start-up the display shows the decoded operating mode number.
// - Switch 1 on selects four-sensor muting, off selects two-sensor muting.
// - Switch 2 on selects sequence-controlled muting, off selects timing-controlled muting.
// - Switch 3 on enables muting-enable and timeout extension, off disables it.
// - Switch 4 on selects manual restart via the acknowledgment unit, off automatic via control.
// - Switch 5 on takes the muting signal from muting sensor 1, off from the control input.
// - Switch 6 on takes reset from the control input, off from the acknowledgment unit.
// - Switches 7 and 8 set the timeout: off/off 20 s, off/on 2 min, on/off 10 min, on/on 100 h.
// - The error output is high while a fault is present and low while fault-free and operating.
`timescale 1ns/1ps
module dip_config_validator (
  input wire logic clk,
  input wire logic reset,
  input wire logic [dip_config_pkg::SW_COUNT-1:0] switch_block_a,
  input wire logic [dip_config_pkg::SW_COUNT-1:0] switch_block_b,
  input wire logic safety_request,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic safety_switching_output_1,
  output logic safety_switching_output_2,
  output logic error_out,
  output logic config_ready,
  output logic four_sensor,
  output logic sequence_mode,
  output logic extension_enable,
  output logic restart_manual,
  output logic muting_from_sensor,
  output logic reset_from_control,
  output logic [1:0] timeout_select,
  output logic [18:0] timeout_seconds,
  output logic [5:0] mode_number,
  output logic [6:0] display_tens,
  output logic [6:0] display_ones
);
  import dip_config_pkg::*;

  // decodes one block into {permitted, mode number}
  function automatic logic [6:0] decode_mode(input logic [SW_COUNT-1:0] sw);
    logic [5:0] base;
    logic ok;
    base = MODE_TIMING_BASE;
    ok = 1'b0;
    if (!sw[SW_FOUR_SENSOR] && !sw[SW_SEQUENCE]) begin
      // timing controlled: 16 modes over switches 3..6
      ok = 1'b1;
      base = MODE_TIMING_BASE + {2'b00, sw[SW_EXTENSION], sw[SW_RESTART_MANUAL],
                                 !sw[SW_MUTE_FROM_SENSOR], sw[SW_RESET_FROM_CONTROL]};
    end else if (sw[SW_SEQUENCE] && !sw[SW_EXTENSION]) begin
      // sequence controlled only without extension
      ok = 1'b1;
      base = (sw[SW_FOUR_SENSOR] ? MODE_SEQ4_BASE : MODE_SEQ2_BASE) +
             {3'b000, sw[SW_RESTART_MANUAL], !sw[SW_MUTE_FROM_SENSOR],
              sw[SW_RESET_FROM_CONTROL]};
    end
    decode_mode = {ok, base};
  endfunction

  // timeout figure for a switch 7/8 pair
  function automatic logic [18:0] timeout_of(input logic [1:0] sel);
    case (sel)
      2'b00: timeout_of = TIMEOUT_SHORT_SEC;
      2'b01: timeout_of = TIMEOUT_MID_SEC;
      2'b10: timeout_of = TIMEOUT_LONG_SEC;
      default: timeout_of = TIMEOUT_MAX_SEC;
    endcase
  endfunction

  // switch synchronisers: three stages, change taken once stages two
  // and three agree, so a bouncing contact never reads half-way
  // the price is about four clocks of delay on every switch edge
  logic [2*SW_COUNT-1:0] raw_pins;
  logic [2*SW_COUNT-1:0] sync1_q;
  logic [2*SW_COUNT-1:0] sync2_q;
  logic [2*SW_COUNT-1:0] sync3_q;
  logic [2*SW_COUNT-1:0] filt_q;

  assign raw_pins = {switch_block_b, switch_block_a};

  generate
    for (genvar i = 0; i < 2 * SW_COUNT; i++) begin : g_sync
      // stage one feeds stage two only
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
          sync3_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= raw_pins[i];
          sync2_q[i] <= sync1_q[i];
          sync3_q[i] <= sync2_q[i];
        end
      end

      // filtered level moves only on agreement
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          filt_q[i] <= 1'b0;
        end else if (sync2_q[i] == sync3_q[i]) begin
          filt_q[i] <= sync3_q[i];
        end
      end
    end
  endgenerate

  logic [SW_COUNT-1:0] live_a;
  logic [SW_COUNT-1:0] live_b;

  assign live_a = filt_q[SW_COUNT-1:0];
  assign live_b = filt_q[2*SW_COUNT-1:SW_COUNT];

  // microsecond tick from a divider, used for the start-up settle
  // a slow enable keeps the settle counter narrow
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // load state machine
  // settle, run and a terminal fault that only reset leaves
  load_state_type state_q;
  logic [$clog2(SETTLE_TICKS+1)-1:0] settle_q;
  logic settle_done;
  logic [SW_COUNT-1:0] stored_q;
  logic [6:0] live_decode;
  logic blocks_differ;
  logic live_changed;
  logic mode_bad;
  logic fault_now;

  assign settle_done = (settle_q == ($clog2(SETTLE_TICKS+1))'(SETTLE_TICKS));
  assign live_decode = decode_mode(live_a);
  assign blocks_differ = (live_a != live_b);
  assign live_changed = (state_q == LOAD_RUN) &&
                        ((live_a != stored_q) || (live_b != stored_q));
  assign mode_bad = !live_decode[6];

  // checks are only armed once the pins have had time to settle
  assign fault_now = settle_done && (blocks_differ || live_changed || mode_bad);

  // settle counter waits out contact bounce after power-on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_q <= '0;
    end else if (tick_q && !settle_done) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  // settle, then sample once; a fault is terminal until reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= LOAD_SETTLE;
    end else begin
      case (state_q)
        LOAD_SETTLE: begin
          if (fault_now) begin
            state_q <= LOAD_FAULT;
          end else if (settle_done) begin
            state_q <= LOAD_RUN;
          end
        end
        LOAD_RUN: begin
          if (fault_now) begin
            state_q <= LOAD_FAULT;
          end
        end
        LOAD_FAULT: state_q <= LOAD_FAULT;
        default: state_q <= LOAD_FAULT;
      endcase
    end
  end

  // snapshot of the configuration taken at the move to run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stored_q <= '0;
    end else if (state_q == LOAD_SETTLE && settle_done && !fault_now) begin
      stored_q <= live_a;
    end
  end

  // decoded settings, frozen from live_a alongside the snapshot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      four_sensor <= 1'b0;
      sequence_mode <= 1'b0;
      extension_enable <= 1'b0;
      restart_manual <= 1'b0;
      muting_from_sensor <= 1'b0;
      reset_from_control <= 1'b0;
      timeout_select <= 2'b00;
      timeout_seconds <= TIMEOUT_SHORT_SEC;
      mode_number <= 6'h00;
    end else if (state_q == LOAD_SETTLE && settle_done && !fault_now) begin
      four_sensor <= live_a[SW_FOUR_SENSOR];
      sequence_mode <= live_a[SW_SEQUENCE];
      extension_enable <= live_a[SW_EXTENSION];
      restart_manual <= live_a[SW_RESTART_MANUAL];
      muting_from_sensor <= live_a[SW_MUTE_FROM_SENSOR];
      reset_from_control <= live_a[SW_RESET_FROM_CONTROL];
      timeout_select <= {live_a[SW_TIMEOUT_FIRST], live_a[SW_TIMEOUT_SECOND]};
      timeout_seconds <= timeout_of({live_a[SW_TIMEOUT_FIRST],
                                     live_a[SW_TIMEOUT_SECOND]});
      mode_number <= live_decode[5:0];
    end
  end

  // registers
  // software view: config, status, mask, control and live pins
  logic [ST_WIDTH-1:0] status_q;
  logic [ST_WIDTH-1:0] mask_q;
  logic enable_q;
  logic [ST_WIDTH-1:0] events;
  logic [ST_WIDTH-1:0] clear_bits;
  logic entering_run;

  assign entering_run = (state_q == LOAD_SETTLE) && settle_done && !fault_now;

  // each fault kind records once per cause; ready marks start-up done
  always_comb begin
    events = '0;
    events[ST_MISMATCH] = fault_now && blocks_differ && (state_q != LOAD_FAULT);
    events[ST_CHANGED] = fault_now && live_changed && (state_q != LOAD_FAULT);
    events[ST_MODE_ERROR] = fault_now && mode_bad && (state_q != LOAD_FAULT);
    events[ST_READY] = entering_run;
  end

  assign clear_bits = (reg_write && reg_addr == ADDR_STATUS) ?
                      reg_wdata[ST_WIDTH-1:0] : '0;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_bits) | events;
    end
  end

  // mask and output enable written by software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_q <= MASK_RESET;
      enable_q <= CONTROL_ENABLE_RESET;
    end else if (reg_write) begin
      if (reg_addr == ADDR_MASK) begin
        mask_q <= reg_wdata[ST_WIDTH-1:0];
      end
      if (reg_addr == ADDR_CONTROL) begin
        enable_q <= reg_wdata[0];
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_CONFIG: begin
          reg_rdata <= '0;
          reg_rdata[SW_COUNT-1:0] <= stored_q;
          reg_rdata[CFG_VALID_BIT] <= (state_q == LOAD_RUN);
          reg_rdata[CFG_MODE_LSB +: 6] <= mode_number;
        end
        ADDR_STATUS: reg_rdata <= {{(32-ST_WIDTH){1'b0}}, status_q};
        ADDR_MASK: reg_rdata <= {{(32-ST_WIDTH){1'b0}}, mask_q};
        ADDR_CONTROL: reg_rdata <= {31'h0000_0000, enable_q};
        ADDR_LIVE: reg_rdata <= {16'h0000, live_b, live_a};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_q & ~clear_bits | events) & mask_q);
    end
  end

  // safety outputs and error pin
  // both outputs come from one term so they cannot disagree
  logic outputs_allowed;

  // outputs only follow the request in run with no fault pending;
  // the fault term is combinational so the drop lands the same edge
  assign outputs_allowed = (state_q == LOAD_RUN) && !fault_now && enable_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      safety_switching_output_1 <= 1'b0;
      safety_switching_output_2 <= 1'b0;
    end else begin
      safety_switching_output_1 <= outputs_allowed && safety_request;
      safety_switching_output_2 <= outputs_allowed && safety_request;
    end
  end

  // error high in fault, low once running clean
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      error_out <= 1'b0;
      config_ready <= 1'b0;
    end else begin
      error_out <= (state_q == LOAD_FAULT) || fault_now;
      config_ready <= (state_q == LOAD_RUN) && !fault_now;
    end
  end

  // mode number on the display once running
  mode_display u_display (
    .clk(clk),
    .reset(reset),
    .show(state_q == LOAD_RUN),
    .fault(state_q == LOAD_FAULT),
    .mode(mode_number),
    .tens_seg(display_tens),
    .ones_seg(display_ones)
  );

endmodule

// ---- tb/switch_blocks_model.sv ----
`timescale 1ns/1ps
// two hand-set switch blocks; the second is meant to copy the first
module switch_blocks_model (
  input wire logic [7:0] setting,
  input wire logic [7:0] flip_b,
  output logic [7:0] block_a,
  output logic [7:0] block_b
);
  // switches hold their level; only the bench decides to misset block b
  assign block_a = setting;
  assign block_b = setting ^ flip_b;
endmodule

// ---- tb/dip_config_validator_properties.sv ----
`timescale 1ns/1ps
// port-level watch on the configuration checker
module dip_config_validator_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] switch_block_a,
  input wire logic [7:0] switch_block_b,
  input wire logic safety_request,
  input wire logic safety_switching_output_1,
  input wire logic safety_switching_output_2,
  input wire logic error_out,
  input wire logic config_ready,
  input wire logic four_sensor,
  input wire logic sequence_mode,
  input wire logic [1:0] timeout_select,
  input wire logic [18:0] timeout_seconds,
  input wire logic [5:0] mode_number,
  input wire logic [6:0] display_tens,
  input wire logic [6:0] display_ones
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // output pair and fault relations
  property p_pair; safety_switching_output_1 == safety_switching_output_2; endproperty
  a_pair: assert property (p_pair) else $error("safety outputs differ");
  property p_err_off; error_out |-> !safety_switching_output_1; endproperty
  a_err_off: assert property (p_err_off) else $error("output on during fault");
  property p_out_cause;
    safety_switching_output_1 |-> config_ready && $past(safety_request);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output on without cause");
  property p_latch; error_out |=> error_out; endproperty
  a_latch: assert property (p_latch) else $error("fault not held");
  property p_ready_ok; config_ready |-> !error_out; endproperty
  a_ready_ok: assert property (p_ready_ok) else $error("ready with fault");
  // live supervision in run; the filter costs a few cycles
  property p_mismatch; config_ready && (switch_block_a != switch_block_b) |-> ##[1:8] error_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("block mismatch missed");
  property p_change;
    config_ready && $changed({switch_block_a, switch_block_b}) |-> ##[1:8] error_out;
  endproperty
  a_change: assert property (p_change) else $error("switch change missed");
  // stored decode
  property p_stored; config_ready ##1 config_ready |-> $stable(mode_number); endproperty
  a_stored: assert property (p_stored) else $error("mode moved in run");
  property p_mode_ok;
    config_ready |-> mode_number inside {[6'd1:6'd24], [6'd49:6'd56]};
  endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("run with bad mode");
  property p_timing_two; config_ready && !sequence_mode |-> !four_sensor; endproperty
  a_timing_two: assert property (p_timing_two) else $error("timing mode with four");
  property p_timeout;
    config_ready |-> timeout_seconds == (timeout_select == 2'b00 ? 19'd20 :
      timeout_select == 2'b01 ? 19'd120 : timeout_select == 2'b10 ? 19'd600 : 19'd360000);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout decode wrong");
  property p_fault_show;
    error_out ##1 error_out ##1 error_out |-> display_tens == 7'h79 && display_ones == 7'h00;
  endproperty
  a_fault_show: assert property (p_fault_show) else $error("fault not shown");
  c_run: cover property ($rose(config_ready));
  c_fault: cover property ($rose(error_out));
  c_on: cover property ($rose(safety_switching_output_1));
endmodule

bind dip_config_validator dip_config_validator_checker chk_u (
  .clk(clk), .reset(reset), .switch_block_a(switch_block_a), .switch_block_b(switch_block_b),
  .safety_request(safety_request), .safety_switching_output_1(safety_switching_output_1),
  .safety_switching_output_2(safety_switching_output_2), .error_out(error_out),
  .config_ready(config_ready), .four_sensor(four_sensor), .sequence_mode(sequence_mode),
  .timeout_select(timeout_select), .timeout_seconds(timeout_seconds),
  .mode_number(mode_number), .display_tens(display_tens), .display_ones(display_ones)
);

// ---- tb/dip_config_validator_bench.sv ----
`timescale 1ns/1ps
module dip_config_validator_bench;
  import dip_config_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] setting = 8'h01;
  logic [7:0] flip_b = 8'h00;
  logic [7:0] sw_a;
  logic [7:0] sw_b;
  logic safety_request = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, safe_1, safe_2, error_out, config_ready;
  logic [5:0] flags;
  logic [1:0] timeout_select;
  logic [18:0] timeout_seconds;
  logic [5:0] mode_number;
  logic [6:0] tens;
  logic [6:0] ones;
  int fails = 0;
  int n_checks = 0;

  // free-running 100 mhz clock
  always #5 clk = ~clk;

  switch_blocks_model part_u (.setting(setting), .flip_b(flip_b), .block_a(sw_a), .block_b(sw_b));

  dip_config_validator dut_u (
    .clk(clk), .reset(reset), .switch_block_a(sw_a), .switch_block_b(sw_b),
    .safety_request(safety_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .safety_switching_output_1(safe_1), .safety_switching_output_2(safe_2),
    .error_out(error_out), .config_ready(config_ready), .four_sensor(flags[0]),
    .sequence_mode(flags[1]), .extension_enable(flags[2]), .restart_manual(flags[3]),
    .muting_from_sensor(flags[4]), .reset_from_control(flags[5]),
    .timeout_select(timeout_select), .timeout_seconds(timeout_seconds),
    .mode_number(mode_number), .display_tens(tens), .display_ones(ones)
  );

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes, then an idle edge so no strobe is set twice at one edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
    @(posedge clk);
  endtask

  // settle lasts about 2000 cycles, so the 3000-cycle bound sits half as much again above it
  task automatic wait_for(input logic want_err);
    int n;
    n = 0;
    while ((want_err ? error_out : config_ready) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      fails++;
      $display("[ERR] wait expected 1 seen 0");
    end
  endtask

  // fresh power-on with a new setting, then the frozen decode
  task run_mode(input logic [7:0] s, input logic [5:0] f, input logic [1:0] ts,
                input logic [18:0] sec, input logic [5:0] m, input logic [6:0] t,
                input logic [6:0] o);
    reset <= 1'b1;
    setting <= s;
    safety_request <= 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wait_for(1'b0);
    repeat (3) @(posedge clk);
    #1;
    check("flags", flags, f);
    check("tsel", timeout_select, ts);
    check("tsec", timeout_seconds, sec);
    check("mode", mode_number, m);
    check("tens", tens, t);
    check("ones", ones, o);
    $display("test mode %0d done", m);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: five settle spans plus margin
  initial begin
    #250000;
    fails++;
    $display("[ERR] watchdog expected done seen hang");
    end_sim;
  end

  // main sequence
  initial begin
    // four sensors with timing control is no permitted mode
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wr(ADDR_CONTROL, 32'h1);
    safety_request <= 1'b1;
    wait_for(1'b1);
    repeat (3) @(posedge clk);
    #1;
    check("error", error_out, 1'b1);
    check("outputs", {safe_1, safe_2}, 2'b00);
    check("ready", config_ready, 1'b0);
    check("tens", tens, 7'h79);
    rd(ADDR_STATUS, 32'h4, "status");
    $display("test bad mode done");
    // mode 12: timing, extension, automatic, control sources, 10 min
    run_mode(8'h64, 6'h24, 2'b10, 19'd600, 6'd12, 7'h06, 7'h5b);
    check("ready", config_ready, 1'b1);
    check("error", error_out, 1'b0);
    check("irq", irq, 1'b0);
    rd(ADDR_CONFIG, 32'h000c_0164, "config");
    rd(ADDR_LIVE, 32'h0000_6464, "live");
    rd(ADDR_STATUS, 32'h8, "status");
    rd(8'h20, 32'h0, "unmapped");
    // ready event through the mask, then cleared by writing one
    wr(ADDR_MASK, 32'h8);
    rd(ADDR_MASK, 32'h8, "mask");
    #1;
    check("irq", irq, 1'b1);
    wr(ADDR_STATUS, 32'h8);
    @(posedge clk);
    #1;
    check("irq", irq, 1'b0);
    wr(ADDR_MASK, 32'h3);
    wr(ADDR_CONTROL, 32'h1);
    safety_request <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("outputs", {safe_1, safe_2}, 2'b11);
    safety_request <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("outputs", {safe_1, safe_2}, 2'b00);
    safety_request <= 1'b1;
    repeat (3) @(posedge clk);
    // switch 8 of block b moves while running
    flip_b <= 8'h80;
    repeat (10) @(posedge clk);
    #1;
    check("error", error_out, 1'b1);
    check("outputs", {safe_1, safe_2}, 2'b00);
    check("irq", irq, 1'b1);
    rd(ADDR_STATUS, 32'h3, "status");
    // putting the switch back does not lift the fault
    flip_b <= 8'h00;
    repeat (12) @(posedge clk);
    #1;
    check("error", error_out, 1'b1);
    check("outputs", {safe_1, safe_2}, 2'b00);
    $display("test run faults done");
    // mode 53: four sensors, sequence, manual, sensor 1 muting, 100 h
    run_mode(8'hdb, 6'h1b, 2'b11, 19'd360000, 6'd53, 7'h6d, 7'h4f);
    // mode 20: two sensors, sequence, control sources, 20 s
    run_mode(8'h22, 6'h22, 2'b00, 19'd20, 6'd20, 7'h5b, 7'h3f);
    // mode 1: timing, sensor 1 muting, acknowledgment reset, 2 min
    run_mode(8'h90, 6'h10, 2'b01, 19'd120, 6'd1, 7'h3f, 7'h06);
    end_sim;
  end
endmodule
